// >>> hdl/rtcs_i2c_slave.sv
`timescale 1ns/10ps
`default_nettype none
module rtcs_i2c_slave #(
  parameter int unsigned TIMEOUT_CYCLES = rtcs_pkg::TIMEOUT_CYC,
  parameter int unsigned FILT_LEN = rtcs_pkg::FILT_LEN
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // register write stream
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [rtcs_pkg::PTR_W-1:0] wr_addr,
  output logic [rtcs_pkg::DATA_W-1:0] wr_data,
  // register read port
  output logic [rtcs_pkg::PTR_W-1:0] rd_addr,
  input wire logic [rtcs_pkg::DATA_W-1:0] rd_data,
  output logic rd_strobe,
  // status
  output logic bus_busy,
  output logic bus_timeout
);

  localparam int unsigned TW = $clog2(TIMEOUT_CYCLES);
  localparam int unsigned BW = rtcs_pkg::PTR_W + rtcs_pkg::DATA_W;

  // ***************************************
  // elaboration checks
  // ***************************************
  // sync plus filter delay must fit well inside the shortest scl half period
  if (TIMEOUT_CYCLES < 2) begin : g_chk_tmo
    $error("rtcs_i2c_slave: TIMEOUT_CYCLES must be at least 2");
  end
  if (FILT_LEN + 4 >= rtcs_pkg::SCL_HALF_CYC) begin : g_chk_rate
    $error("rtcs_i2c_slave: filter too slow for 400 kHz scl");
  end

  // ***************************************
  // state
  // ***************************************
  typedef struct packed {
    rtcs_pkg::rtcs_state_e st;
    logic scl_d;
    logic sda_d;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic rw;
    logic ptr_phase;
    logic nack;
    logic [rtcs_pkg::PTR_W-1:0] ptr;
    logic oe;
    logic busy;
    logic [TW-1:0] tmo;
    logic tmo_pulse;
    logic push;
    logic [BW-1:0] push_word;
    logic rd_stb;
  } rtcs_slave_s;

  rtcs_slave_s s_r;
  rtcs_slave_s s_nxt;
  logic [1:0] lvl;
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic buf_ready;

  // ***************************************
  // pin conditioning
  // ***************************************
  rtcs_in_filter #(
    .N_IN(2),
    .STABLE(FILT_LEN)
  ) u_filter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_i({scl_i, sda_i}),
    .level_o(lvl)
  );

  assign scl_f = lvl[1];
  assign sda_f = lvl[0];
  assign scl_rise = scl_f & ~s_r.scl_d;
  assign scl_fall = ~scl_f & s_r.scl_d;
  assign start_det = scl_f & s_r.scl_d & s_r.sda_d & ~sda_f;
  assign stop_det = scl_f & s_r.scl_d & ~s_r.sda_d & sda_f;

  // ***************************************
  // write buffer
  // ***************************************
  // scl cannot be stretched, so a full buffer turns into a nack instead
  rtcs_buf2 #(
    .WIDTH(BW),
    .DEPTH(rtcs_pkg::BUF_DEPTH)
  ) u_wbuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(s_r.push),
    .in_ready(buf_ready),
    .in_data(s_r.push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );

  // ***************************************
  // protocol engine
  // ***************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_d = scl_f;
    s_nxt.sda_d = sda_f;
    s_nxt.push = 1'b0;
    s_nxt.rd_stb = 1'b0;
    s_nxt.tmo_pulse = 1'b0;
    if (s_r.busy) begin
      s_nxt.tmo = s_r.tmo + TW'(1);
    end
    if (start_det) begin
      // a repeated start simply restarts; nothing of a write is left half done
      s_nxt.st = rtcs_pkg::ST_ADDR;
      s_nxt.cnt = '0;
      s_nxt.oe = 1'b0;
      s_nxt.busy = 1'b1;
      s_nxt.tmo = '0;
    end else if (stop_det) begin
      s_nxt.st = rtcs_pkg::ST_IDLE;
      s_nxt.oe = 1'b0;
      s_nxt.busy = 1'b0;
      s_nxt.tmo = '0;
    end else if (s_r.busy && s_r.tmo == TW'(TIMEOUT_CYCLES - 1)) begin
      // standby until the next start: sda stays released, so reads see FFh
      s_nxt.st = rtcs_pkg::ST_IDLE;
      s_nxt.oe = 1'b0;
      s_nxt.busy = 1'b0;
      s_nxt.tmo = '0;
      s_nxt.tmo_pulse = 1'b1;
    end else begin
      case (s_r.st)
        rtcs_pkg::ST_ADDR: begin
          if (scl_rise && s_r.cnt != rtcs_pkg::BYTE_BITS) begin
            s_nxt.shift = {s_r.shift[6:0], sda_f};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end
          if (scl_fall && s_r.cnt == rtcs_pkg::BYTE_BITS) begin
            if (s_r.shift[7:1] == rtcs_pkg::SLAVE_ADDR) begin
              s_nxt.rw = s_r.shift[rtcs_pkg::RW_BIT];
              s_nxt.ptr_phase = ~s_r.shift[rtcs_pkg::RW_BIT];
              s_nxt.oe = 1'b1;
              s_nxt.st = rtcs_pkg::ST_ADDR_ACK;
            end else begin
              s_nxt.st = rtcs_pkg::ST_SKIP;
            end
          end
        end
        rtcs_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (s_r.rw) begin
              // read starts at the pointer, whatever set it last
              s_nxt.shift = rd_data;
              s_nxt.oe = ~rd_data[7];
              s_nxt.cnt = '0;
              s_nxt.rd_stb = 1'b1;
              s_nxt.st = rtcs_pkg::ST_RD;
            end else begin
              s_nxt.oe = 1'b0;
              s_nxt.cnt = '0;
              s_nxt.st = rtcs_pkg::ST_WR;
            end
          end
        end
        rtcs_pkg::ST_WR: begin
          if (scl_rise && s_r.cnt != rtcs_pkg::BYTE_BITS) begin
            s_nxt.shift = {s_r.shift[6:0], sda_f};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end
          if (scl_fall && s_r.cnt == rtcs_pkg::BYTE_BITS) begin
            s_nxt.st = rtcs_pkg::ST_WR_ACK;
            if (s_r.ptr_phase) begin
              s_nxt.ptr = s_r.shift;
              s_nxt.ptr_phase = 1'b0;
              s_nxt.oe = 1'b1;
            end else if (buf_ready && !s_r.push) begin
              s_nxt.push = 1'b1;
              s_nxt.push_word = {s_r.ptr, s_r.shift};
              s_nxt.ptr = s_r.ptr + 8'h01;
              s_nxt.oe = 1'b1;
            end else begin
              s_nxt.oe = 1'b0;
            end
          end
        end
        rtcs_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            s_nxt.oe = 1'b0;
            s_nxt.cnt = '0;
            s_nxt.st = rtcs_pkg::ST_WR;
          end
        end
        rtcs_pkg::ST_RD: begin
          if (scl_fall) begin
            if (s_r.cnt == rtcs_pkg::LAST_BIT) begin
              s_nxt.oe = 1'b0;
              s_nxt.ptr = s_r.ptr + 8'h01;
              s_nxt.st = rtcs_pkg::ST_RD_ACK;
            end else begin
              s_nxt.shift = {s_r.shift[6:0], 1'b1};
              s_nxt.oe = ~s_r.shift[6];
              s_nxt.cnt = s_r.cnt + 4'h1;
            end
          end
        end
        rtcs_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            s_nxt.nack = sda_f;
          end
          if (scl_fall) begin
            if (s_r.nack) begin
              s_nxt.st = rtcs_pkg::ST_SKIP;
            end else begin
              s_nxt.shift = rd_data;
              s_nxt.oe = ~rd_data[7];
              s_nxt.cnt = '0;
              s_nxt.rd_stb = 1'b1;
              s_nxt.st = rtcs_pkg::ST_RD;
            end
          end
        end
        rtcs_pkg::ST_IDLE, rtcs_pkg::ST_SKIP: begin
          s_nxt.oe = 1'b0;
        end
        default: begin
          s_nxt.st = rtcs_pkg::ST_IDLE;
          s_nxt.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{
        st: rtcs_pkg::ST_IDLE,
        scl_d: 1'b1,
        sda_d: 1'b1,
        shift: '0,
        cnt: '0,
        rw: 1'b0,
        ptr_phase: 1'b0,
        nack: 1'b0,
        ptr: rtcs_pkg::PTR_RST,
        oe: 1'b0,
        busy: 1'b0,
        tmo: '0,
        tmo_pulse: 1'b0,
        push: 1'b0,
        push_word: '0,
        rd_stb: 1'b0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************
  // outputs
  // ***************************************
  // open drain: the pin is only ever pulled low, never driven high
  assign sda_o = 1'b0;
  assign sda_oe = s_r.oe;
  assign rd_addr = s_r.ptr;
  assign rd_strobe = s_r.rd_stb;
  assign bus_busy = s_r.busy;
  assign bus_timeout = s_r.tmo_pulse;

endmodule : rtcs_i2c_slave
`default_nettype wire

// >>> shared/rtcs_pkg.sv
`default_nettype none
package rtcs_pkg;

  // ***************************************
  // clock and timing
  // ***************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SCL_MAX_HZ = 400_000;
  localparam int unsigned TIMEOUT_S = 1;
  localparam int unsigned TIMEOUT_CYC = CLK_HZ * TIMEOUT_S;
  // shortest scl half period in core cycles, rounded down
  localparam int unsigned SCL_HALF_CYC = CLK_HZ / (SCL_MAX_HZ * 2);
  localparam int unsigned FILT_LEN = 3;

  // ***************************************
  // protocol fields
  // ***************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h51;
  localparam int unsigned RW_BIT = 0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W = 8;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam int unsigned BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h2,
    ST_WR = 3'h3,
    ST_WR_ACK = 3'h4,
    ST_RD = 3'h5,
    ST_RD_ACK = 3'h6,
    ST_SKIP = 3'h7
  } rtcs_state_e;

endpackage : rtcs_pkg
`default_nettype wire

// >>> hdl/rtcs_in_filter.sv
`timescale 1ns/10ps
`default_nettype none
module rtcs_in_filter #(
  parameter int unsigned N_IN = 2,
  parameter int unsigned STABLE = rtcs_pkg::FILT_LEN
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // raw pins and filtered levels
  input wire logic [N_IN-1:0] pin_i,
  output logic [N_IN-1:0] level_o
);

  localparam int unsigned CW = (STABLE < 2) ? 1 : $clog2(STABLE);

  if (STABLE < 1 || N_IN < 1) begin : g_chk
    $error("rtcs_in_filter: STABLE and N_IN must be at least 1");
  end

  // ***************************************
  // one synchroniser and filter per lane
  // ***************************************
  for (genvar i = 0; i < N_IN; i++) begin : g_lane
    typedef struct packed {
      logic s0;
      logic s1;
      logic [CW-1:0] cnt;
      logic q;
    } rtcs_lane_s;

    rtcs_lane_s lane_r;
    rtcs_lane_s lane_nxt;

    always_comb begin
      lane_nxt = lane_r;
      lane_nxt.s0 = pin_i[i];
      lane_nxt.s1 = lane_r.s0;
      // s0 feeds only s1; the filter looks at s1 alone
      if (lane_r.s1 == lane_r.q) begin
        lane_nxt.cnt = '0;
      end else if (lane_r.cnt == CW'(STABLE - 1)) begin
        lane_nxt.q = lane_r.s1;
        lane_nxt.cnt = '0;
      end else begin
        lane_nxt.cnt = lane_r.cnt + CW'(1);
      end
    end

    // idle bus is high, so the lanes reset high
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        lane_r <= '{s0: 1'b1, s1: 1'b1, cnt: '0, q: 1'b1};
      end else begin
        lane_r <= lane_nxt;
      end
    end

    assign level_o[i] = lane_r.q;
  end

endmodule : rtcs_in_filter
`default_nettype wire

// >>> hdl/rtcs_buf2.sv
`timescale 1ns/10ps
`default_nettype none
module rtcs_buf2 #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = rtcs_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("rtcs_buf2: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rtcs_buf_s;

  rtcs_buf_s buf_r;
  rtcs_buf_s buf_nxt;
  logic push;
  logic pop;

  assign in_ready = (buf_r.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (buf_r.cnt != '0);
  assign out_data = buf_r.mem[buf_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    buf_nxt = buf_r;
    if (push) begin
      buf_nxt.mem[buf_r.wp] = in_data;
      buf_nxt.wp = buf_r.wp + AW'(1);
    end
    if (pop) begin
      buf_nxt.rp = buf_r.rp + AW'(1);
    end
    if (push && !pop) begin
      buf_nxt.cnt = buf_r.cnt + (AW + 1)'(1);
    end else if (pop && !push) begin
      buf_nxt.cnt = buf_r.cnt - (AW + 1)'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r <= '0;
    end else begin
      buf_r <= buf_nxt;
    end
  end

endmodule : rtcs_buf2
`default_nettype wire

// >>> test/rtcs_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module rtcs_master_model #(
  parameter int unsigned Q = 16
) (
  // clock
  input wire logic core_clk,
  // bus wires
  input wire logic sda_w,
  output logic scl,
  output logic sda_low
);
  // ***************************************
  // bus master, quarter bit = Q core cycles
  // ***************************************
  // 64 cycles per bit keeps the rate just under 400 kHz
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  task automatic wait_q();
    repeat (Q) @(posedge core_clk);
  endtask : wait_q

  // entered from idle or with scl low, so a restart is clean
  task automatic send_start();
    sda_low <= 1'h0;
    wait_q();
    scl <= 1'h1;
    wait_q();
    sda_low <= 1'h1;
    wait_q();
    scl <= 1'h0;
  endtask : send_start

  task automatic send_stop();
    sda_low <= 1'h1;
    wait_q();
    scl <= 1'h1;
    wait_q();
    sda_low <= 1'h0;
    wait_q();
  endtask : send_stop

  task automatic bit_io(input logic b, output logic r);
    wait_q();
    sda_low <= ~b;
    wait_q();
    scl <= 1'h1;
    wait_q();
    r = sda_w;
    wait_q();
    scl <= 1'h0;
  endtask : bit_io

  // b9 released for write acks; low acks a read byte, high ends the read
  task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] r,
                      output logic s9);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(b9, s9);
  endtask : xfer
endmodule : rtcs_master_model
`default_nettype wire

// >>> test/rtcs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rtcs_chk #(
  parameter int unsigned TIMEOUT_CYCLES = 2000,
  parameter int unsigned FILT_LEN = 3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_strobe,
  input wire logic bus_busy,
  input wire logic bus_timeout
);
  // ***************************************
  // port relations
  // ***************************************
  // sync, filter and edge register plus margin
  localparam int DET_MAX = int'(FILT_LEN) + 9;
  logic [31:0] busy_cnt_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= 32'h0;
    end else begin
      busy_cnt_r <= bus_busy ? busy_cnt_r + 32'h1 : 32'h0;
    end
  end

  // pin-level conditions held long enough to pass the filter
  sequence s_start;
    (scl_i && $fell(sda_i)) ##1 (scl_i && !sda_i) [*4];
  endsequence
  sequence s_stop;
    (scl_i && $rose(sda_i)) ##1 (scl_i && sda_i) [*4];
  endsequence

  a_start_busy: assert property (s_start |-> ##[1:DET_MAX] bus_busy)
    else $error("busy not raised after start");
  a_stop_idle: assert property (s_stop |-> ##[1:DET_MAX] !bus_busy)
    else $error("busy not cleared after stop");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda drive changed while scl high");
  a_idle_release: assert property (!bus_busy && !$past(bus_busy) |-> !sda_oe)
    else $error("sda driven outside a transfer");
  a_open_drain: assert property (sda_oe |-> sda_o == 1'h0)
    else $error("sda driven high");
  a_timeout_bound: assert property (busy_cnt_r <= TIMEOUT_CYCLES + 1)
    else $error("busy outlived the timeout");
  a_timeout_pulse: assert property (bus_timeout |-> $past(bus_busy) ##1 !bus_timeout)
    else $error("timeout pulse malformed");
  a_ptr_step: assert property ($rose(wr_valid) |-> rd_addr == wr_addr + 8'h01)
    else $error("pointer not advanced by one");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
    else $error("stalled write word changed");
  a_strobe_pulse: assert property (rd_strobe |-> bus_busy ##1 (!rd_strobe && $stable(rd_addr)))
    else $error("read strobe malformed");
endmodule : rtcs_chk

bind rtcs_i2c_slave rtcs_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .FILT_LEN(FILT_LEN)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
  .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .rd_strobe(rd_strobe),
  .bus_busy(bus_busy), .bus_timeout(bus_timeout));
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ***************************************
  // harness
  // ***************************************
  localparam int unsigned TMO = 8000;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic wr_ready = 1'h1;
  logic scl, sda_low, sda_i, sda_o, sda_oe, wr_valid, rd_strobe, bus_busy, bus_timeout;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  logic [15:0] words[$];
  int fail_count = 0;
  int total_checks = 0;
  int tmo_cnt = 0;

  always #20 core_clk = ~core_clk;
  // pulled-up wire: low if either party drives
  assign sda_i = ~sda_low & (sda_oe ? sda_o : 1'h1);
  // register file stand-in, a fixed pattern of the address
  assign rd_data = rd_addr ^ 8'hA5;
  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) words.push_back({wr_addr, wr_data});
    if (bus_timeout === 1'h1) tmo_cnt++;
  end

  rtcs_master_model #(.Q(16)) m (.core_clk(core_clk), .sda_w(sda_i), .scl(scl),
    .sda_low(sda_low));
  rtcs_i2c_slave #(.TIMEOUT_CYCLES(TMO), .FILT_LEN(3)) dut (.core_clk(core_clk),
    .rst_n(rst_n), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_strobe(rd_strobe), .bus_busy(bus_busy),
    .bus_timeout(bus_timeout));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  task automatic put(input logic [7:0] d, input logic ack);
    logic [7:0] r;
    logic s;
    m.xfer(d, 1'h1, r, s);
    // concatenation keeps the inversion one bit wide
    chk({15'h0000, s}, {15'h0000, ~ack});
  endtask : put

  task automatic get(input logic [7:0] exp, input logic last);
    logic [7:0] r;
    logic s;
    m.xfer(8'hFF, last, r, s);
    chk({8'h00, r}, {8'h00, exp});
  endtask : get

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // ***************************************
  // scenarios
  // ***************************************
  task automatic t_write_wrap();
    words.delete();
    m.send_start();
    put(8'hA2, 1'h1);
    put(8'hFE, 1'h1);
    put(8'h11, 1'h1);
    put(8'h22, 1'h1);
    put(8'h33, 1'h1);
    m.send_stop();
    idle(20);
    chk(16'(bus_busy), 16'h0000);
    chk(16'(words.size()), 16'h0003);
    chk(words[0], 16'hFE11);
    chk(words[1], 16'hFF22);
    chk(words[2], 16'h0033);
    $display("done write_wrap");
  endtask : t_write_wrap

  task automatic t_read_at();
    words.delete();
    m.send_start();
    put(8'hA2, 1'h1);
    put(8'h40, 1'h1);
    m.send_start();
    put(8'hA3, 1'h1);
    get(8'h40 ^ 8'hA5, 1'h0);
    get(8'h41 ^ 8'hA5, 1'h0);
    get(8'h42 ^ 8'hA5, 1'h1);
    m.send_stop();
    idle(20);
    chk(16'(bus_busy), 16'h0000);
    chk({8'h00, rd_addr}, 16'h0043);
    chk(16'(words.size()), 16'h0000);
    $display("done read_at");
  endtask : t_read_at

  task automatic t_cur_read();
    m.send_start();
    put(8'hA3, 1'h1);
    get(8'h43 ^ 8'hA5, 1'h0);
    get(8'h44 ^ 8'hA5, 1'h1);
    m.send_stop();
    idle(20);
    chk({8'h00, rd_addr}, 16'h0045);
    $display("done cur_read");
  endtask : t_cur_read

  task automatic t_foreign();
    logic [7:0] adr[3] = '{8'hA0, 8'hE2, 8'hA6};
    words.delete();
    foreach (adr[i]) begin
      m.send_start();
      put(adr[i], 1'h0);
      put(8'h77, 1'h0);
      m.send_stop();
    end
    idle(20);
    chk(16'(words.size()), 16'h0000);
    chk({8'h00, rd_addr}, 16'h0045);
    $display("done foreign");
  endtask : t_foreign

  // consumer stalls, so the third data byte finds the buffer full
  task automatic t_full();
    words.delete();
    wr_ready <= 1'h0;
    m.send_start();
    put(8'hA2, 1'h1);
    put(8'h10, 1'h1);
    put(8'h01, 1'h1);
    put(8'h02, 1'h1);
    put(8'h03, 1'h0);
    m.send_stop();
    wr_ready <= 1'h1;
    idle(20);
    chk(16'(words.size()), 16'h0002);
    chk(words[0], 16'h1001);
    chk(words[1], 16'h1102);
    chk({8'h00, rd_addr}, 16'h0012);
    $display("done full");
  endtask : t_full

  task automatic t_timeout();
    int n;
    words.delete();
    n = tmo_cnt;
    m.send_start();
    put(8'hA2, 1'h1);
    put(8'h20, 1'h1);
    idle(TMO + 200);
    chk(16'(tmo_cnt - n), 16'h0001);
    chk(16'(bus_busy), 16'h0000);
    put(8'h55, 1'h0);
    get(8'hFF, 1'h1);
    m.send_stop();
    chk(16'(words.size()), 16'h0000);
    m.send_start();
    put(8'hA3, 1'h1);
    get(8'h20 ^ 8'hA5, 1'h1);
    m.send_stop();
    $display("done timeout");
  endtask : t_timeout

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    idle(4);
    t_write_wrap();
    t_read_at();
    t_cur_read();
    t_foreign();
    t_full();
    t_timeout();
    end_sim();
  end

  // whole run needs about 27000 cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
